// ### rtl/frt_defs.svh
// register indices, field positions, reset values and timing counts of the capture timer
`ifndef FRT_DEFS_SVH
`define FRT_DEFS_SVH

// ****************************************
// register indices (byte address is four times the index)
// ****************************************
`define FRT_IDX_CNT_LOW 6'h20
`define FRT_IDX_CNT_HIGH 6'h21
`define FRT_IDX_A_RISE 6'h22
`define FRT_IDX_B_RISE 6'h23
`define FRT_IDX_A_FALL 6'h24
`define FRT_IDX_B_FALL 6'h25
`define FRT_IDX_CONFIG 6'h2a
`define FRT_IDX_ENABLE 6'h2b
`define FRT_IDX_STATUS 6'h2c

// ****************************************
// field positions
// ****************************************
`define FRT_CFG_HOLD_BIT 7
`define FRT_CFG_WIN_MSB 6
`define FRT_CFG_WIN_LSB 4
`define FRT_CFG_JOIN_BIT 3
`define FRT_CFG_USED_MASK 8'hf8
`define FRT_SRC_MASK 8'h0f

// ****************************************
// reset values
// ****************************************
`define FRT_RST_BYTE 8'h00
`define FRT_RST_COUNT 16'h0000
`define FRT_RST_SRC 4'h0

// ****************************************
// timing
// ****************************************
`define FRT_TMR_CLK_KHZ 4000
`define FRT_TICK_US 1024
`define FRT_TICK_COUNTS ((`FRT_TICK_US * `FRT_TMR_CLK_KHZ) / 1000)
`define FRT_SYNC_STAGES 3

`endif

// ### rtl/frt_pkg.sv
// types shared by the capture timer files
package frt_pkg;
	typedef logic [7:0] frt_byte_t;
	typedef logic [5:0] frt_idx_t;
	typedef logic [15:0] frt_count_t;
	typedef logic [3:0] frt_src_t;
endpackage

// ### rtl/frt_sync.sv
// three-stage pin synchroniser with debounced level and one-cycle edge pulses
`timescale 1ns/100ps
`include "frt_defs.svh"
module frt_sync (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic pin,
	output logic rise,
	output logic fall
);
	// ****************************************
	// synchroniser chain
	// ****************************************
	logic [`FRT_SYNC_STAGES-1:0] chain;
	logic level;
	wire agree = chain[1] == chain[2];
	wire next_rise = agree & chain[2] & ~level;
	wire next_fall = agree & ~chain[2] & level;

	// first stage feeds only the second; decisions look at stages two and three
	always_ff @(posedge clk) begin
		if (rst) begin
			chain <= '0;
			level <= 1'b0;
			rise <= 1'b0;
			fall <= 1'b0;
		end else if (ce) begin
			chain <= {chain[1:0], pin};
			if (agree) begin
				level <= chain[2];
			end
			rise <= next_rise;
			fall <= next_fall;
		end
	end
endmodule

// ### rtl/frt_capture.sv
// free-running counter with two edge-capture channels behind an avalon-mm slave
`timescale 1ns/100ps
`include "frt_defs.svh"
// Function
// - 16-bit counter advances on timer clock
// - timer clock sampled safely into bus clock
// - low-byte read latches high byte
// - low write pending, high write loads
// - periodic tick every 4096 counts
// - wrap event on counter overflow
// - two channels, four capture registers
// - hold off: latest edge overwrites
// - hold on: first edge kept until read
// - window select picks bits n+7:n
// - joined: channel b holds high byte
// - joined: channel a holds low byte
// - 8-bit mode: each channel own input
// - enable bits gate capture events
// - status bit set on its capture
// - write one clears status bit
module frt_capture (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic timer_time_base_clock,
	input wire logic capture_input_a,
	input wire logic capture_input_b,
	output logic tick_event,
	output logic wrap_event,
	output logic [3:0] capture_event_req
);
	// ****************************************
	// functions
	// ****************************************
	// selected eight-bit window of the counter
	function automatic frt_pkg::frt_byte_t win_bits(input frt_pkg::frt_count_t c,
		input logic [2:0] n);
		frt_pkg::frt_count_t s;
		s = c >> n;
		return s[7:0];
	endfunction

	// true when the bus index names the given register
	function automatic logic reg_hit(input frt_pkg::frt_idx_t a,
		input frt_pkg::frt_idx_t r);
		return a == r;
	endfunction

	// keep a byte register unless its load strobe is up
	function automatic frt_pkg::frt_byte_t take_if(input logic en,
		input frt_pkg::frt_byte_t d, input frt_pkg::frt_byte_t q);
		return en ? d : q;
	endfunction

	// ****************************************
	// state
	// ****************************************
	frt_pkg::frt_count_t count;
	frt_pkg::frt_byte_t hold_high;
	frt_pkg::frt_byte_t pend_low;
	frt_pkg::frt_byte_t cfg;
	frt_pkg::frt_src_t irq_en;
	frt_pkg::frt_src_t flags;
	frt_pkg::frt_src_t lock;
	frt_pkg::frt_byte_t cap_a_rise;
	frt_pkg::frt_byte_t cap_a_fall;
	frt_pkg::frt_byte_t cap_b_rise;
	frt_pkg::frt_byte_t cap_b_fall;

	// ****************************************
	// input synchronisers
	// ****************************************
	logic tclk_rise;
	logic a_rise;
	logic a_fall;
	logic b_rise;
	logic b_fall;

	// the timer clock is treated as a sampled pin; it must stay well below clk / 4
	frt_sync u_tclk (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.pin(timer_time_base_clock),
		.rise(tclk_rise),
		.fall()
	);

	frt_sync u_in_a (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.pin(capture_input_a),
		.rise(a_rise),
		.fall(a_fall)
	);

	frt_sync u_in_b (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.pin(capture_input_b),
		.rise(b_rise),
		.fall(b_fall)
	);

	// ****************************************
	// bus decode
	// ****************************************
	// one wait cycle: read data and read side effects at the first edge,
	// writes at the edge where the master sees waitrequest low
	wire frt_pkg::frt_idx_t idx = avs_address[7:2];
	wire req = avs_read | avs_write;
	wire rd_fire = avs_read & avs_waitrequest;
	wire wr_fire = avs_write & ~avs_waitrequest & avs_byteenable[0];
	wire frt_pkg::frt_byte_t wbyte = avs_writedata[7:0];
	// each index is decoded once for the read and write strobes; the read data mux decodes idx again in its own case
	wire hit_low = reg_hit(idx, `FRT_IDX_CNT_LOW);
	wire hit_high = reg_hit(idx, `FRT_IDX_CNT_HIGH);
	wire hit_a_rise = reg_hit(idx, `FRT_IDX_A_RISE);
	wire hit_b_rise = reg_hit(idx, `FRT_IDX_B_RISE);
	wire hit_a_fall = reg_hit(idx, `FRT_IDX_A_FALL);
	wire hit_b_fall = reg_hit(idx, `FRT_IDX_B_FALL);
	wire hit_cfg = reg_hit(idx, `FRT_IDX_CONFIG);
	wire hit_en = reg_hit(idx, `FRT_IDX_ENABLE);
	wire hit_stat = reg_hit(idx, `FRT_IDX_STATUS);
	wire rd_low = rd_fire & hit_low;
	wire wr_low = wr_fire & hit_low;
	wire wr_high = wr_fire & hit_high;
	wire wr_cfg = wr_fire & hit_cfg;
	wire wr_en = wr_fire & hit_en;
	wire wr_stat = wr_fire & hit_stat;
	wire rd_a_rise = rd_fire & hit_a_rise;
	wire rd_a_fall = rd_fire & hit_a_fall;
	wire rd_b_rise = rd_fire & hit_b_rise;
	wire rd_b_fall = rd_fire & hit_b_fall;
	wire frt_pkg::frt_src_t rd_cap = {rd_b_fall, rd_b_rise, rd_a_fall, rd_a_rise};

	logic [7:0] rd_mux;
	always_comb begin
		unique case (idx)
			`FRT_IDX_CNT_LOW: rd_mux = count[7:0];
			`FRT_IDX_CNT_HIGH: rd_mux = hold_high;
			`FRT_IDX_A_RISE: rd_mux = cap_a_rise;
			`FRT_IDX_B_RISE: rd_mux = cap_b_rise;
			`FRT_IDX_A_FALL: rd_mux = cap_a_fall;
			`FRT_IDX_B_FALL: rd_mux = cap_b_fall;
			`FRT_IDX_CONFIG: rd_mux = cfg & `FRT_CFG_USED_MASK;
			`FRT_IDX_ENABLE: rd_mux = {4'h0, irq_en};
			`FRT_IDX_STATUS: rd_mux = {4'h0, flags};
			default: rd_mux = `FRT_RST_BYTE;
		endcase
	end

	// ****************************************
	// counter
	// ****************************************
	localparam logic [11:0] TICK_MASK = 12'(`FRT_TICK_COUNTS - 1);
	wire next_tick = tclk_rise & ~wr_high & (count[11:0] == TICK_MASK);
	wire next_wrap = tclk_rise & ~wr_high & (count == 16'hffff);
	wire frt_pkg::frt_count_t count_inc = frt_pkg::frt_count_t'(count + 16'h0001);
	wire frt_pkg::frt_count_t count_load = {wbyte, pend_low};
	wire frt_pkg::frt_count_t next_count = wr_high ? count_load :
		(tclk_rise ? count_inc : count);

	// ****************************************
	// capture
	// ****************************************
	wire hold = cfg[`FRT_CFG_HOLD_BIT];
	wire join16 = cfg[`FRT_CFG_JOIN_BIT];
	wire frt_pkg::frt_byte_t win = win_bits(count,
		cfg[`FRT_CFG_WIN_MSB:`FRT_CFG_WIN_LSB]);
	wire frt_pkg::frt_byte_t data_a = join16 ? count[7:0] : win;
	wire frt_pkg::frt_byte_t data_b = join16 ? count[15:8] : win;
	// in joined mode channel b follows input a and ignores its own pin
	wire frt_pkg::frt_src_t edge_ev = {join16 ? a_fall : b_fall,
		join16 ? a_rise : b_rise, a_fall, a_rise};
	// a read that clears a lock lets an edge of the same cycle load
	wire frt_pkg::frt_src_t lock_eff = lock & ~rd_cap;
	wire frt_pkg::frt_src_t hold_mask = lock_eff & {4{hold}};
	wire frt_pkg::frt_src_t load = edge_ev & ~hold_mask;
	wire frt_pkg::frt_src_t next_lock = hold ? (lock_eff | load) : `FRT_RST_SRC;
	wire frt_pkg::frt_src_t stat_clr = wr_stat ? wbyte[3:0] : `FRT_RST_SRC;
	// a capture in the same cycle as its clear still sets the flag
	wire frt_pkg::frt_src_t next_flags = (flags & ~stat_clr) | load;

	// ****************************************
	// next values
	// ****************************************
	// read data are taken at the request edge, so they stand through the answer cycle
	wire next_waitrequest = ~(req & avs_waitrequest);
	wire [31:0] next_readdata = rd_fire ? {24'h000000, rd_mux} : avs_readdata;
	wire frt_pkg::frt_byte_t next_hold_high = take_if(rd_low, count[15:8], hold_high);
	wire frt_pkg::frt_byte_t next_pend_low = take_if(wr_low, wbyte, pend_low);
	wire frt_pkg::frt_byte_t next_cfg = take_if(wr_cfg, wbyte & `FRT_CFG_USED_MASK, cfg);
	wire frt_pkg::frt_src_t next_irq_en = wr_en ? wbyte[3:0] : irq_en;
	wire frt_pkg::frt_src_t next_event_req = flags & irq_en;
	wire frt_pkg::frt_byte_t next_cap_a_rise = take_if(load[0], data_a, cap_a_rise);
	wire frt_pkg::frt_byte_t next_cap_a_fall = take_if(load[1], data_a, cap_a_fall);
	wire frt_pkg::frt_byte_t next_cap_b_rise = take_if(load[2], data_b, cap_b_rise);
	wire frt_pkg::frt_byte_t next_cap_b_fall = take_if(load[3], data_b, cap_b_fall);

	// ****************************************
	// registers
	// ****************************************
	// one short process per register; ce low freezes every one of them
	always_ff @(posedge clk) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
		end else if (ce) begin
			avs_waitrequest <= next_waitrequest;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			avs_readdata <= '0;
		end else if (ce) begin
			avs_readdata <= next_readdata;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			count <= `FRT_RST_COUNT;
		end else if (ce) begin
			count <= next_count;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			hold_high <= `FRT_RST_BYTE;
		end else if (ce) begin
			hold_high <= next_hold_high;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pend_low <= `FRT_RST_BYTE;
		end else if (ce) begin
			pend_low <= next_pend_low;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			tick_event <= 1'b0;
		end else if (ce) begin
			tick_event <= next_tick;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wrap_event <= 1'b0;
		end else if (ce) begin
			wrap_event <= next_wrap;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cfg <= `FRT_RST_BYTE;
		end else if (ce) begin
			cfg <= next_cfg;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			irq_en <= `FRT_RST_SRC;
		end else if (ce) begin
			irq_en <= next_irq_en;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			flags <= `FRT_RST_SRC;
		end else if (ce) begin
			flags <= next_flags;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			lock <= `FRT_RST_SRC;
		end else if (ce) begin
			lock <= next_lock;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			capture_event_req <= `FRT_RST_SRC;
		end else if (ce) begin
			capture_event_req <= next_event_req;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cap_a_rise <= `FRT_RST_BYTE;
		end else if (ce) begin
			cap_a_rise <= next_cap_a_rise;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cap_a_fall <= `FRT_RST_BYTE;
		end else if (ce) begin
			cap_a_fall <= next_cap_a_fall;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cap_b_rise <= `FRT_RST_BYTE;
		end else if (ce) begin
			cap_b_rise <= next_cap_b_rise;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cap_b_fall <= `FRT_RST_BYTE;
		end else if (ce) begin
			cap_b_fall <= next_cap_b_fall;
		end
	end
endmodule

// ### tb/frt_checker.sv
// assertions on the capture timer ports
`timescale 1ns/100ps
module frt_checker (
	input wire logic clk,
	input wire logic rst,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic timer_time_base_clock,
	input wire logic capture_input_a,
	input wire logic capture_input_b,
	input wire logic tick_event,
	input wire logic wrap_event,
	input wire logic [3:0] capture_event_req
);
	// ***
	// single clock domain
	// ***
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer missing");
	single_ack_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("answer held too long");
	reset_quiet_a: assert property ($fell(rst) |-> avs_waitrequest && capture_event_req == 4'h0)
		else $error("outputs not cleared");
	tick_pulse_a: assert property (tick_event |=> !tick_event)
		else $error("tick too long");
	wrap_tick_a: assert property (wrap_event |-> tick_event ##1 !wrap_event)
		else $error("wrap without tick");
	upper_zero_a: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
		else $error("upper read bits set");
	// quiet pins and no writes leave the event lines alone
	pins_quiet_a: assert property ((!avs_write && $stable(capture_input_a)
		&& $stable(capture_input_b)) [*8] |=> $stable(capture_event_req))
		else $error("event without edge");
	timer_idle_a: assert property ((!timer_time_base_clock && !avs_write) [*8]
		|=> !tick_event && !wrap_event)
		else $error("counter moved");
endmodule
bind frt_capture frt_checker frt_checker_i (.*);

// ### tb/frt_pin_src.sv
// two external signal sources on the capture pins
`timescale 1ns/100ps
module frt_pin_src (
	input wire logic clk,
	input wire logic want_a,
	input wire logic want_b,
	output logic pin_a,
	output logic pin_b
);
	// levels change on the clock; the bench keeps each for 10 cycles, past the synchroniser
	always @(posedge clk) begin
		pin_a <= want_a;
		pin_b <= want_b;
	end
endmodule

// ### tb/frt_capture_test.sv
// self-checking bench for the capture timer
`timescale 1ns/100ps
module frt_capture_test;
	logic clk, rst, rd, wr, tclk, want_a, want_b, wreq, tick, wrap, pa, pb;
	logic [7:0] addr;
	logic [31:0] wdata, rdata;
	logic [3:0] req, en;
	logic [15:0] c, c2, e;
	logic [7:0] expq[$];
	int fail_count = 0;
	int samples_checked = 0;
	int ticks = 0;
	int wraps = 0;
	frt_capture frt_capture_i (.clk(clk), .rst(rst), .ce(1'b1), .avs_address(addr),
		.avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(4'h1),
		.avs_readdata(rdata), .avs_waitrequest(wreq), .timer_time_base_clock(tclk),
		.capture_input_a(pa), .capture_input_b(pb), .tick_event(tick), .wrap_event(wrap),
		.capture_event_req(req));
	frt_pin_src frt_pin_src_i (.clk(clk), .want_a(want_a), .want_b(want_b), .pin_a(pa),
		.pin_b(pb));
	// ***
	// tasks
	// ***
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// a read only notes its expected byte; the watcher compares
	task bus(input logic w, input logic [5:0] i, input logic [7:0] d);
		int k;
		k = 0;
		@(posedge clk);
		addr <= {i, 2'h0};
		rd <= !w;
		wr <= w;
		wdata <= {24'h0, d};
		if (!w)
			expq.push_back(d);
		do
			@(posedge clk);
		while (wreq !== 1'b0 && ++k < 99);
		rd <= 1'b0;
		wr <= 1'b0;
		if (k >= 99) begin
			fail_count++;
			report_and_stop();
		end
	endtask
	task setc(input logic [15:0] v);
		bus(1'b1, 6'h20, v[7:0]);
		bus(1'b1, 6'h21, v[15:8]);
	endtask
	// 4 mhz timer clock, kept still between bursts so counts stay known
	task tpulse(input int n);
		repeat (n) begin
			tclk <= 1'b1;
			repeat (5) @(posedge clk);
			tclk <= 1'b0;
			repeat (5) @(posedge clk);
		end
	endtask
	task pins(input logic a, input logic b);
		want_a <= a;
		want_b <= b;
		repeat (10) @(posedge clk);
	endtask
	task rd4(input logic [15:0] r, input logic [15:0] f);
		bus(1'b0, 6'h22, r[7:0]);
		bus(1'b0, 6'h23, r[15:8]);
		bus(1'b0, 6'h24, f[7:0]);
		bus(1'b0, 6'h25, f[15:8]);
	endtask
	always @(posedge clk) begin
		if (rd && wreq === 1'b0)
			chk(rdata, {24'h0, expq.pop_front()});
		ticks <= ticks + (tick === 1'b1);
		wraps <= wraps + (wrap === 1'b1);
	end
	initial begin
		clk = 1'b0;
		forever
			#12.5 clk = ~clk;
	end
	// ***
	// scenarios
	// ***
	initial begin
		rst = 1'b1;
		rd = 1'b0;
		wr = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		tclk = 1'b0;
		want_a = 1'b0;
		want_b = 1'b0;
		c = 16'($urandom(32'h9c9f));
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		for (int i = 32; i < 46; i++)
			bus(1'b0, i[5:0], 8'h00);
		$display("reset values done");
		c = {c[15:12], 12'h3ff};
		setc(c);
		bus(1'b0, 6'h20, 8'hff);
		tpulse(2);
		bus(1'b0, 6'h21, c[15:8]);
		c = c + 16'h2;
		bus(1'b0, 6'h20, c[7:0]);
		bus(1'b0, 6'h21, c[15:8]);
		$display("counter done");
		for (int n = 0; n < 8; n++) begin
			c = 16'($urandom);
			c2 = 16'($urandom);
			en = 4'($urandom);
			bus(1'b1, 6'h2b, {4'h0, en});
			bus(1'b1, 6'h2a, {1'b0, 3'(n), 4'h0});
			setc(c);
			pins(1'b1, 1'b1);
			setc(c2);
			pins(1'b0, 1'b0);
			e = c >> n;
			c = c2 >> n;
			rd4({2{e[7:0]}}, {2{c[7:0]}});
			bus(1'b0, 6'h2c, 8'h0f);
			chk({28'h0, req}, {28'h0, en});
			bus(1'b1, 6'h2c, 8'h05);
			bus(1'b0, 6'h2c, 8'h0a);
			bus(1'b1, 6'h2c, 8'h0a);
			bus(1'b0, 6'h2c, 8'h00);
		end
		$display("window capture done");
		for (int h = 0; h < 2; h++) begin
			c2 = c ^ 16'h00a5;
			bus(1'b1, 6'h2a, {h[0], 7'h0});
			pins(1'b0, 1'b0);
			setc(c);
			pins(1'b1, 1'b0);
			pins(1'b0, 1'b0);
			setc(c2);
			pins(1'b1, 1'b0);
			e = h ? c : c2;
			bus(1'b0, 6'h22, e[7:0]);
			pins(1'b0, 1'b0);
			pins(1'b1, 1'b0);
			bus(1'b0, 6'h22, c2[7:0]);
		end
		$display("first edge hold done");
		c = ~c2;
		bus(1'b1, 6'h2a, 8'h38);
		bus(1'b1, 6'h2c, 8'h0f);
		setc(c);
		pins(1'b0, 1'b1);
		setc(c2);
		pins(1'b1, 1'b0);
		rd4(c2, c);
		bus(1'b0, 6'h2c, 8'h0f);
		$display("joined capture done");
		bus(1'b1, 6'h2a, 8'h00);
		setc(16'hffee);
		tpulse(20);
		bus(1'b0, 6'h20, 8'h02);
		setc(16'h0ffe);
		tpulse(4);
		chk(32'(ticks), 32'h2);
		chk(32'(wraps), 32'h1);
		$display("tick and wrap done");
		report_and_stop();
	end
endmodule
